// ---- pcacv_pkg.sv ----
/*
 * pcacv_pkg: constants for the counter-array channel 1/2 value registers.
 * assumes: byte-wide special-function-register bus, byte addresses as printed.
 */
package pcacv_pkg;
   // ************************************************************
   // register addresses
   // ************************************************************
   localparam logic [7:0] ADDR_CHAN1_VALUE_LOW  = 8'hE9;
   localparam logic [7:0] ADDR_CHAN1_VALUE_HIGH = 8'hEA;
   localparam logic [7:0] ADDR_CHAN2_VALUE_LOW  = 8'hEB;
   localparam logic [7:0] ADDR_CHAN2_VALUE_HIGH = 8'hEC;
   // ************************************************************
   // reset values and field positions
   // ************************************************************
   localparam logic [7:0] RST_BYTE              = 8'h00;
   localparam int         MODE_CMP_EN_BIT       = 6;
   localparam int         MODE_WIDE_PWM_BIT     = 7;
   localparam int         NUM_CHAN              = 2;
endpackage

// ---- pcacv_value_regs.sv ----
/*
 * pcacv_value_regs: low/high value bytes and auto-reload bytes for
 * capture/compare channels 1 and 2, with the comparator-enable side effects.
 * assumes: the processor drives sfr_* on clk_sys_i; one access per cycle;
 * the mode registers live elsewhere and take cmp_en_set/clr pulses;
 * reload_select_i comes from the pwm control register on the same clock.
 */
module pcacv_value_regs #(
   parameter int NCH = pcacv_pkg::NUM_CHAN
) (
   input  wire logic           clk_sys_i,
   input  wire logic           rst_i,
   input  wire logic [7:0]     sfr_addr_i,
   input  wire logic [7:0]     sfr_wdata_i,
   input  wire logic           sfr_wr_i,
   input  wire logic           sfr_rd_i,
   input  wire logic           reload_select_i,
   output logic      [7:0]     sfr_rdata_o,
   output logic                sfr_hit_o,
   output logic      [NCH-1:0] cmp_en_set_o,
   output logic      [NCH-1:0] cmp_en_clr_o,
   output logic      [15:0]    chan1_compare_o,
   output logic      [15:0]    chan2_compare_o,
   output logic      [15:0]    chan1_reload_o,
   output logic      [15:0]    chan2_reload_o
);
   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic [NCH-1:0][7:0] val_lo;
      logic [NCH-1:0][7:0] val_hi;
      logic [NCH-1:0][7:0] rld_lo;
      logic [NCH-1:0][7:0] rld_hi;
      logic [7:0]          rdata;
      logic                hit;
      logic [NCH-1:0]      en_set;
      logic [NCH-1:0]      en_clr;
   } pcacv_state_t;

   pcacv_state_t st_r;
   pcacv_state_t st_nxt;

   // returns channel index and high/low of a mapped address
   function automatic logic decode(input logic [7:0] a, output int ch, output logic hi);
      ch = 0;
      hi = 1'b0;
      decode = 1'b1;
      unique case (a)
         pcacv_pkg::ADDR_CHAN1_VALUE_LOW: begin ch = 0; hi = 1'b0; end
         pcacv_pkg::ADDR_CHAN1_VALUE_HIGH: begin ch = 0; hi = 1'b1; end
         pcacv_pkg::ADDR_CHAN2_VALUE_LOW: begin ch = 1; hi = 1'b0; end
         pcacv_pkg::ADDR_CHAN2_VALUE_HIGH: begin ch = 1; hi = 1'b1; end
         default: decode = 1'b0;
      endcase
   endfunction

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      int   ch;
      logic hi;
      logic mapped;
      ch = 0;
      hi = 1'b0;
      mapped = 1'b0;
      st_nxt = st_r;
      st_nxt.en_set = '0;
      st_nxt.en_clr = '0;
      st_nxt.hit = 1'b0;
      mapped = decode(sfr_addr_i, ch, hi);
      if (mapped && sfr_wr_i) begin
         if (!hi) begin
            if (reload_select_i) st_nxt.rld_lo[ch] = sfr_wdata_i;
            else st_nxt.val_lo[ch] = sfr_wdata_i;
            st_nxt.en_clr[ch] = 1'b1;
         end else begin
            if (reload_select_i) st_nxt.rld_hi[ch] = sfr_wdata_i;
            else st_nxt.val_hi[ch] = sfr_wdata_i;
            st_nxt.en_set[ch] = 1'b1;
         end
      end
      // read data registered; held until the next read
      if (mapped && sfr_rd_i) begin
         st_nxt.hit = 1'b1;
         if (!hi) st_nxt.rdata = reload_select_i ? st_r.rld_lo[ch] : st_r.val_lo[ch];
         else st_nxt.rdata = reload_select_i ? st_r.rld_hi[ch] : st_r.val_hi[ch];
      end else if (sfr_rd_i) begin
         st_nxt.rdata = pcacv_pkg::RST_BYTE;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   // mode register applies set/clr to bit MODE_CMP_EN_BIT; wide pwm bit there picks width
   assign sfr_rdata_o     = st_r.rdata;
   assign sfr_hit_o       = st_r.hit;
   assign cmp_en_set_o    = st_r.en_set;
   assign cmp_en_clr_o    = st_r.en_clr;
   assign chan1_compare_o = {st_r.val_hi[0], st_r.val_lo[0]};
   assign chan2_compare_o = {st_r.val_hi[1], st_r.val_lo[1]};
   assign chan1_reload_o  = {st_r.rld_hi[0], st_r.rld_lo[0]};
   assign chan2_reload_o  = {st_r.rld_hi[1], st_r.rld_lo[1]};

   // ************************************************************
   // checks
   // ************************************************************
   sequence s_low_wr(int c, logic [7:0] a);
      sfr_wr_i && sfr_addr_i == a;
   endsequence

   // read strobe alone, so the old value is what comes back
   sequence s_read_cmd(logic [7:0] a);
      sfr_rd_i && !sfr_wr_i && sfr_addr_i == a;
   endsequence

   // any address outside the four mapped bytes
   sequence s_unmapped;
      sfr_addr_i != pcacv_pkg::ADDR_CHAN1_VALUE_LOW && sfr_addr_i != pcacv_pkg::ADDR_CHAN1_VALUE_HIGH &&
      sfr_addr_i != pcacv_pkg::ADDR_CHAN2_VALUE_LOW && sfr_addr_i != pcacv_pkg::ADDR_CHAN2_VALUE_HIGH;
   endsequence

   // ************************************************************
   // checks: comparator enable side effects
   // ************************************************************
   a_low_clears_en2: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      s_low_wr(1, pcacv_pkg::ADDR_CHAN2_VALUE_LOW) |=> cmp_en_clr_o[1] && !cmp_en_set_o[1])
      else $error("chan2 low write did not clear enable");
   a_high_sets_en1: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      sfr_wr_i && sfr_addr_i == pcacv_pkg::ADDR_CHAN1_VALUE_HIGH |=> cmp_en_set_o[0] && !cmp_en_clr_o[0])
      else $error("chan1 high write did not set enable");
   a_unmapped_quiet: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      sfr_wr_i ##0 s_unmapped |=> cmp_en_set_o == '0 && cmp_en_clr_o == '0)
      else $error("unmapped write touched enable");
   a_pulse_exclusive: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (cmp_en_set_o & cmp_en_clr_o) == '0)
      else $error("enable set and clear together");

   // ************************************************************
   // checks: reset, stores and reads, and chan1 low / chan2 high enable side effects
   // ************************************************************
   a_reset_clear: assert property (@(posedge clk_sys_i)
      rst_i |=> chan1_compare_o == '0 && chan2_compare_o == '0 && chan1_reload_o == '0 && chan2_reload_o == '0)
      else $error("value bytes not cleared by reset");
   a_val_lo_store2: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      sfr_wr_i && !reload_select_i && sfr_addr_i == pcacv_pkg::ADDR_CHAN2_VALUE_LOW
      |=> chan2_compare_o[7:0] == $past(sfr_wdata_i))
      else $error("chan2 low not stored");
   a_val_hi_store1: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      sfr_wr_i && !reload_select_i && sfr_addr_i == pcacv_pkg::ADDR_CHAN1_VALUE_HIGH
      |=> chan1_compare_o[15:8] == $past(sfr_wdata_i))
      else $error("chan1 high not stored");
   a_rld_lo_store1: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      sfr_wr_i && reload_select_i && sfr_addr_i == pcacv_pkg::ADDR_CHAN1_VALUE_LOW
      |=> chan1_reload_o[7:0] == $past(sfr_wdata_i) && $stable(chan1_compare_o))
      else $error("chan1 reload low not stored");
   a_rld_hi_store2: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      sfr_wr_i && reload_select_i && sfr_addr_i == pcacv_pkg::ADDR_CHAN2_VALUE_HIGH
      |=> chan2_reload_o[15:8] == $past(sfr_wdata_i) && $stable(chan2_compare_o))
      else $error("chan2 reload high not stored");
   a_sel_read2: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      reload_select_i ##0 s_read_cmd(pcacv_pkg::ADDR_CHAN2_VALUE_LOW)
      |=> sfr_rdata_o == $past(chan2_reload_o[7:0]) && sfr_hit_o)
      else $error("chan2 reload read wrong");
   a_unmapped_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      sfr_rd_i ##0 s_unmapped |=> sfr_rdata_o == pcacv_pkg::RST_BYTE && !sfr_hit_o)
      else $error("unmapped read not zero");
   a_cmp_concat1: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      !reload_select_i ##0 s_read_cmd(pcacv_pkg::ADDR_CHAN1_VALUE_HIGH)
      |=> sfr_rdata_o == $past(chan1_compare_o[15:8]))
      else $error("chan1 compare high read wrong");

   a_low_clears_en: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      s_low_wr(0, pcacv_pkg::ADDR_CHAN1_VALUE_LOW) |=> cmp_en_clr_o[0] && !cmp_en_set_o[0])
      else $error("low write did not clear enable");
   a_high_sets_en: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      sfr_wr_i && sfr_addr_i == pcacv_pkg::ADDR_CHAN2_VALUE_HIGH |=> cmp_en_set_o[1] && !cmp_en_clr_o[1])
      else $error("high write did not set enable");
   a_val_lo_store: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      sfr_wr_i && !reload_select_i && sfr_addr_i == pcacv_pkg::ADDR_CHAN1_VALUE_LOW
      |=> chan1_compare_o[7:0] == $past(sfr_wdata_i))
      else $error("chan1 low not stored");
   a_val_hi_store: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      sfr_wr_i && !reload_select_i && sfr_addr_i == pcacv_pkg::ADDR_CHAN2_VALUE_HIGH
      |=> chan2_compare_o[15:8] == $past(sfr_wdata_i))
      else $error("chan2 high not stored");
   a_rld_lo_store: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      sfr_wr_i && reload_select_i && sfr_addr_i == pcacv_pkg::ADDR_CHAN2_VALUE_LOW
      |=> chan2_reload_o[7:0] == $past(sfr_wdata_i) && $stable(chan2_compare_o))
      else $error("chan2 reload low not stored");
   a_rld_hi_store: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      sfr_wr_i && reload_select_i && sfr_addr_i == pcacv_pkg::ADDR_CHAN1_VALUE_HIGH
      |=> chan1_reload_o[15:8] == $past(sfr_wdata_i) && $stable(chan1_compare_o))
      else $error("chan1 reload high not stored");
   a_sel_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      sfr_rd_i && !sfr_wr_i && reload_select_i && sfr_addr_i == pcacv_pkg::ADDR_CHAN1_VALUE_LOW
      |=> sfr_rdata_o == $past(chan1_reload_o[7:0]) && sfr_hit_o)
      else $error("reload read wrong");
   a_cmp_concat: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      sfr_rd_i && !sfr_wr_i && !reload_select_i && sfr_addr_i == pcacv_pkg::ADDR_CHAN2_VALUE_HIGH
      |=> sfr_rdata_o == $past(chan2_compare_o[15:8]))
      else $error("compare high read wrong");
endmodule // pcacv_value_regs

// ---- tb_pcacv_value_regs.sv ----
/*
 * tb_pcacv_value_regs: self-checking bench for the channel 1/2 value and reload bytes.
 * assumes: pcacv_pkg and pcacv_value_regs compiled first; assertions live in the design.
 */
module tb_pcacv_value_regs;
   timeunit 1ns;
   timeprecision 1ns;
   // ************************************************************
   // signals and dut
   // ************************************************************
   logic        clk_sys_i = 1'b0, rst_i = 1'b1, sfr_wr_i = 1'b0, sfr_rd_i = 1'b0, reload_select_i = 1'b0;
   logic [7:0]  sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o;
   logic        sfr_hit_o;
   logic [1:0]  cmp_en_set_o, cmp_en_clr_o;
   logic [15:0] chan1_compare_o, chan2_compare_o, chan1_reload_o, chan2_reload_o;
   logic [15:0] val [2][2] = '{default: 16'h0000};
   logic [7:0]  a, lo, hi;
   int          fail_count = 0, tests_run = 0, cycles = 0;

   pcacv_value_regs i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i),
      .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .reload_select_i(reload_select_i),
      .sfr_rdata_o(sfr_rdata_o), .sfr_hit_o(sfr_hit_o), .cmp_en_set_o(cmp_en_set_o), .cmp_en_clr_o(cmp_en_clr_o),
      .chan1_compare_o(chan1_compare_o), .chan2_compare_o(chan2_compare_o),
      .chan1_reload_o(chan1_reload_o), .chan2_reload_o(chan2_reload_o));

   initial begin
      forever #25 clk_sys_i = ~clk_sys_i;
   end
   // ************************************************************
   // access and compare tasks
   // ************************************************************
   task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   // strobe stands one cycle; results register on the edge that ends it and are read 1 ns after
   task automatic acc(logic wr, logic [7:0] ad, logic [7:0] d, logic sel);
      @(posedge clk_sys_i);
      sfr_wr_i <= wr;
      sfr_rd_i <= ~wr;
      sfr_addr_i <= ad;
      sfr_wdata_i <= d;
      reload_select_i <= sel;
      @(posedge clk_sys_i);
      sfr_wr_i <= 1'b0;
      sfr_rd_i <= 1'b0;
      #1;
   endtask

   task automatic wr(logic [7:0] ad, logic [7:0] d, logic sel, logic [1:0] set, logic [1:0] clr);
      acc(1'b1, ad, d, sel);
      chk("cmp_en_set_o", {14'h0000, set}, {14'h0000, cmp_en_set_o});
      chk("cmp_en_clr_o", {14'h0000, clr}, {14'h0000, cmp_en_clr_o});
   endtask

   task automatic rd(logic [7:0] ad, logic sel, logic [7:0] exp, logic hit);
      acc(1'b0, ad, 8'h00, sel);
      chk("sfr_rdata_o", {8'h00, exp}, {8'h00, sfr_rdata_o});
      chk("sfr_hit_o", {15'h0000, hit}, {15'h0000, sfr_hit_o});
   endtask

   task automatic outs();
      chk("chan1_compare_o", val[0][0], chan1_compare_o);
      chk("chan2_compare_o", val[1][0], chan2_compare_o);
      chk("chan1_reload_o", val[0][1], chan1_reload_o);
      chk("chan2_reload_o", val[1][1], chan2_reload_o);
   endtask

   task automatic test_done();
      if (fail_count == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // whole run is well under 300 cycles
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 2000) begin
         fail_count++;
         test_done();
      end
   end
   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      repeat (5) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      #1;
      outs();
      for (int i = 0; i < 8; i++)
         rd(pcacv_pkg::ADDR_CHAN1_VALUE_LOW + 8'(i % 4), i[2], pcacv_pkg::RST_BYTE, 1'b1);
      for (int c = 0; c < 2; c++) begin
         for (int s = 0; s < 2; s++) begin
            a = pcacv_pkg::ADDR_CHAN1_VALUE_LOW + 8'(c * 2);
            lo = 8'(8'hA1 + c * 2 + s * 4);
            hi = 8'(8'h5C + c + s * 8);
            wr(a, lo, s[0], 2'b00, 2'(1 << c));
            wr(a + 8'h01, hi, s[0], 2'(1 << c), 2'b00);
            val[c][s] = {hi, lo};
            rd(a, s[0], lo, 1'b1);
            rd(a + 8'h01, s[0], hi, 1'b1);
            outs();
         end
      end
      // unmapped neighbours: ignored writes, zero reads, no side effects
      wr(8'hE8, 8'hFF, 1'b0, 2'b00, 2'b00);
      wr(8'hED, 8'hFF, 1'b1, 2'b00, 2'b00);
      rd(8'hED, 1'b0, 8'h00, 1'b0);
      outs();
      @(posedge clk_sys_i);
      rst_i <= 1'b1;
      @(posedge clk_sys_i);
      rst_i <= 1'b0;
      val = '{default: 16'h0000};
      #1;
      outs();
      test_done();
   end
endmodule // tb_pcacv_value_regs
